// ==== rtl/acc_pkg.sv ====
// Constants for the comparator control block
// Summary of operation
// [R01] Result bit 5 reads high while positive input exceeds negative input.
// [R02] Power-off bit 7 set removes comparator power; writable anytime.
// [R03] Software clears irq enable before changing power-off bit.
// [R04] Bit 6 is reserved and always reads zero.
// [R05] Event flag bit 4 sets on transition matching selected event type.
// [R06] Event flag clears when core takes the comparator vector.
// [R07] Writing one to event flag clears it; zero leaves it.
// [R08] Request only when flag, enable bit 3 and global enable set.
// [R09] Routing bit 2 feeds comparator output to timer capture front end.
// [R10] Routing bit clear disconnects comparator from capture function.
// [R11] Software sets timer capture irq enable for capture interrupts.
// [R12] Select bits: 00 toggle, 01 reserved, 10 falling, 11 rising.
// [R13] Software clears irq enable before changing event select bits.
// [R14] Read-modify-write of other bits clears a set event flag.
// [R15] Output sampled on clock; events from current versus previous sample.
package acc_pkg;
   localparam logic [11:0] ACC_CSR_OFF    = 12'h000;
   localparam logic [11:0] ACC_IRQ_ST_OFF = 12'h004;
   localparam logic [11:0] ACC_IRQ_MK_OFF = 12'h008;
   localparam int          ACC_PWROFF_BIT = 7;
   localparam int          ACC_RESV_BIT   = 6;
   localparam int          ACC_RESULT_BIT = 5;
   localparam int          ACC_FLAG_BIT   = 4;
   localparam int          ACC_IRQEN_BIT  = 3;
   localparam int          ACC_ROUTE_BIT  = 2;
   localparam logic [7:0]  ACC_CSR_RST    = 8'h00;
   localparam logic [7:0]  ACC_CSR_WMASK  = 8'h8F;
   localparam logic [1:0]  ACC_SEL_TOGGLE = 2'h0;
   localparam logic [1:0]  ACC_SEL_RESV   = 2'h1;
   localparam logic [1:0]  ACC_SEL_FALL   = 2'h2;
   localparam logic [1:0]  ACC_SEL_RISE   = 2'h3;
   localparam logic [1:0]  ACC_EVT_RST    = 2'h0;
   typedef enum logic [1:0] {
      ACC_EV_TOGGLE,
      ACC_EV_NONE,
      ACC_EV_FALL,
      ACC_EV_RISE
   } acc_evmode_t;
endpackage

// ==== rtl/acc_edge_det.sv ====
// Comparator output sampler and event detector
`timescale 1ns/1ps
`default_nettype none
module acc_edge_det
   import acc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       cmp_in,
   input  wire logic [1:0] sel,
   output logic            sample,
   output logic            evt
);
   logic prev_ff;
   logic nxt_prev;
   logic samp_ff;
   logic nxt_samp;
   logic primed_ff;
   logic nxt_primed;

   function automatic acc_evmode_t decode_sel(input logic [1:0] s);
      case (s)
         ACC_SEL_TOGGLE: decode_sel = ACC_EV_TOGGLE;
         ACC_SEL_FALL:   decode_sel = ACC_EV_FALL;
         ACC_SEL_RISE:   decode_sel = ACC_EV_RISE;
         default:        decode_sel = ACC_EV_NONE;
      endcase
   endfunction

   always_comb begin
      nxt_samp   = cmp_in;
      // First sample loads history too, so no false edge after reset
      nxt_prev   = primed_ff ? samp_ff : cmp_in;
      nxt_primed = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_ff   <= 1'b0;
         prev_ff   <= 1'b0;
         primed_ff <= 1'b0;
      end else begin
         samp_ff   <= nxt_samp; // [R15]
         prev_ff   <= nxt_prev;
         primed_ff <= nxt_primed;
      end
   end

   assign sample = samp_ff;

   always_comb begin
      case (decode_sel(sel)) // [R12]
         ACC_EV_TOGGLE: evt = samp_ff ^ prev_ff; // [R05]
         ACC_EV_FALL:   evt = !samp_ff && prev_ff;
         ACC_EV_RISE:   evt = samp_ff && !prev_ff;
         default:       evt = 1'b0; // Reserved code raises nothing
      endcase
   end

   AST_RISE_EVT: assert property (@(posedge pclk) disable iff (!presetn)
      (sel == ACC_SEL_RISE && samp_ff && !prev_ff) |-> evt) // [R12]
      else $error("rising edge missed");
   AST_RESV_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
      (sel == ACC_SEL_RESV) |-> !evt) // [R12]
      else $error("reserved mode raised event");
   AST_SAMPLE_LAG: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 sample == $past(cmp_in)) // [R15]
      else $error("sample not one clock late");
endmodule // acc_edge_det
`default_nettype wire

// ==== rtl/acc_ctrl.sv ====
// Comparator control/status register block with APB slave
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl
   import acc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cmp_out,
   input  wire logic        capture_pin,
   input  wire logic        global_irq_enable,
   input  wire logic        vector_ack,
   output logic             comparator_power_off,
   output logic             capture_src,
   output logic             comparator_irq_req,
   output logic             irq
);
   logic [7:0]  csr_ff;
   logic [7:0]  nxt_csr;
   logic        flag_ff;
   logic        nxt_flag;
   logic [1:0]  ist_ff;
   logic [1:0]  nxt_ist;
   logic [1:0]  imk_ff;
   logic [1:0]  nxt_imk;
   logic        smp_d_ff;
   logic        nxt_smp_d;
   logic        armed_ff;
   logic        nxt_armed;
   logic [31:0] rd_ff;
   logic [31:0] nxt_rd;
   logic        err_ff;
   logic        nxt_err;
   logic        sample;
   logic        evt;
   logic        wr_acc;
   logic        rd_setup;
   logic        mapped;
   logic        comparator_result;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   acc_edge_det u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .cmp_in  (cmp_out),
      .sel     (csr_ff[1:0]),
      .sample  (sample),
      .evt     (evt)
   );

   // Powered-off comparator reads low and raises no events
   assign comparator_result = sample && !csr_ff[ACC_PWROFF_BIT]; // [R01]

   assign mapped = hit(paddr, ACC_CSR_OFF) || hit(paddr, ACC_IRQ_ST_OFF)
                   || hit(paddr, ACC_IRQ_MK_OFF);
   assign wr_acc   = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable;

   // Control and event flag
   always_comb begin
      nxt_csr  = csr_ff;
      nxt_flag = flag_ff;
      if (wr_acc && hit(paddr, ACC_CSR_OFF) && pstrb[0]) begin
         nxt_csr = pwdata[7:0] & ACC_CSR_WMASK; // [R02]
         if (pwdata[ACC_FLAG_BIT]) begin
            nxt_flag = 1'b0; // [R07]
         end
      end
      if (vector_ack) begin
         nxt_flag = 1'b0; // [R06]
      end
      // Event wins over a clear in the same cycle
      if (evt && !csr_ff[ACC_PWROFF_BIT]) begin
         nxt_flag = 1'b1; // [R05]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csr_ff  <= ACC_CSR_RST;
         flag_ff <= 1'b0;
      end else begin
         csr_ff  <= nxt_csr;
         flag_ff <= nxt_flag;
      end
   end

   // Sticky status: bit0 event, bit1 sample rise while powered
   always_comb begin
      nxt_ist   = ist_ff;
      nxt_imk   = imk_ff;
      // Own copy of the previous sample, primed like the detector
      nxt_smp_d = armed_ff ? sample : cmp_out;
      nxt_armed = 1'b1;
      if (wr_acc && hit(paddr, ACC_IRQ_ST_OFF) && pstrb[0]) begin
         nxt_ist = ist_ff & ~pwdata[1:0];
      end
      if (wr_acc && hit(paddr, ACC_IRQ_MK_OFF) && pstrb[0]) begin
         nxt_imk = pwdata[1:0];
      end
      if (evt && !csr_ff[ACC_PWROFF_BIT]) begin
         nxt_ist[0] = 1'b1;
      end
      if (sample && !smp_d_ff && !csr_ff[ACC_PWROFF_BIT]) begin
         nxt_ist[1] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_ff   <= 2'h0;
         imk_ff   <= 2'h0;
         smp_d_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         ist_ff   <= nxt_ist;
         imk_ff   <= nxt_imk;
         smp_d_ff <= nxt_smp_d;
         armed_ff <= nxt_armed;
      end
   end

   // Read data captured in setup so access phase returns it
   always_comb begin
      nxt_rd  = rd_ff;
      nxt_err = err_ff;
      if (rd_setup) begin
         nxt_err = !mapped;
         nxt_rd  = 32'h0000_0000;
         if (hit(paddr, ACC_CSR_OFF)) begin
            nxt_rd[7:0] = {csr_ff[ACC_PWROFF_BIT], 1'b0, // [R04]
                           comparator_result, flag_ff, // [R01]
                           csr_ff[3:0]}; // [R14]
         end else if (hit(paddr, ACC_IRQ_ST_OFF)) begin
            nxt_rd[1:0] = ist_ff;
         end else if (hit(paddr, ACC_IRQ_MK_OFF)) begin
            nxt_rd[1:0] = imk_ff;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ff  <= 32'h0000_0000;
         err_ff <= 1'b0;
      end else begin
         rd_ff  <= nxt_rd;
         err_ff <= nxt_err;
      end
   end

   assign prdata  = rd_ff;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && err_ff;

   assign comparator_power_off = csr_ff[ACC_PWROFF_BIT]; // [R02]
   // Mux keeps capture pin path when routing off
   assign capture_src = csr_ff[ACC_ROUTE_BIT] ? comparator_result // [R09]
                                              : capture_pin; // [R10]
   assign comparator_irq_req = flag_ff && csr_ff[ACC_IRQEN_BIT] // [R08]
                               && global_irq_enable;
   assign irq = |(ist_ff & imk_ff);

   AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (evt && !csr_ff[ACC_PWROFF_BIT]) |=> flag_ff) // [R05]
      else $error("event did not set flag");
   AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(paddr, ACC_CSR_OFF) && pstrb[0]
       && pwdata[ACC_FLAG_BIT] && !evt) |=> !flag_ff) // [R07]
      else $error("write one did not clear flag");
   AST_W0_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
      (flag_ff && !vector_ack && !(wr_acc && hit(paddr, ACC_CSR_OFF)
       && pwdata[ACC_FLAG_BIT])) |=> flag_ff) // [R07]
      else $error("flag lost without clear");
   AST_VEC_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      (vector_ack && !evt) |=> !flag_ff) // [R06]
      else $error("vector did not clear flag");
   AST_REQ: assert property (@(posedge pclk) disable iff (!presetn)
      comparator_irq_req == (flag_ff && csr_ff[ACC_IRQEN_BIT]
                             && global_irq_enable)) // [R08]
      else $error("request gating wrong");
   AST_RESV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit(paddr, ACC_CSR_OFF))
      |-> !prdata[ACC_RESV_BIT]) // [R04]
      else $error("reserved bit read as one");
   AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
      csr_ff[ACC_ROUTE_BIT] |-> capture_src == comparator_result) // [R09]
      else $error("routing not applied");
   AST_NOROUTE: assert property (@(posedge pclk) disable iff (!presetn)
      !csr_ff[ACC_ROUTE_BIT] |-> capture_src == capture_pin) // [R10]
      else $error("comparator leaked to capture");
   AST_PWROFF: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && hit(paddr, ACC_CSR_OFF) && pstrb[0])
      |=> comparator_power_off == $past(pwdata[ACC_PWROFF_BIT])) // [R02]
      else $error("power-off not written");
   AST_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
      !csr_ff[ACC_PWROFF_BIT] |-> comparator_result == sample) // [R01]
      else $error("result not following comparator");
endmodule // acc_ctrl
`default_nettype wire

// ==== sim/acc_far_model.sv ====
// Far-side model: analog input pair and external capture pin
`timescale 1ns/1ps
`default_nettype none
module acc_far_model (
   input  wire logic [11:0] pos_mv,
   input  wire logic [11:0] neg_mv,
   input  wire logic        pin_lvl,
   output logic             cmp_out,
   output logic             capture_pin
);
   // Ideal comparator, no hysteresis or offset modelled
   assign cmp_out     = (pos_mv > neg_mv);
   assign capture_pin = pin_lvl;
endmodule // acc_far_model
`default_nettype wire

// ==== sim/analog_comparator_ctrl_tb.sv ====
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_ctrl_tb;
   import acc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        cmp_out, capture_pin, gie, vack, pwr_off, cap_src, req, irq;
   logic        pin;
   logic [11:0] paddr, pos_mv, neg_mv;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [1:0]  s;
   logic        up_hit, dn_hit;
   int          mismatches, comparisons, cyc;

   acc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_out(cmp_out), .capture_pin(capture_pin),
      .global_irq_enable(gie), .vector_ack(vack),
      .comparator_power_off(pwr_off), .capture_src(cap_src),
      .comparator_irq_req(req), .irq(irq));
   acc_far_model far (.pos_mv(pos_mv), .neg_mv(neg_mv), .pin_lvl(pin),
      .cmp_out(cmp_out), .capture_pin(capture_pin));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Generous ceiling; the sequence needs a few hundred cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         $display("ERROR %0t: timeout", $time);
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: line %b expected %b", $time, got, exp);
      end
   endtask

   // Master waits for pready, never assumes a latency
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      #1;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
      chk1(err, 1'b0);
   endtask

   // Event shows in the flag two edges after the input moves
   task automatic setv(input logic [11:0] p, input logic [11:0] n);
      @(posedge pclk);
      pos_mv <= p;
      neg_mv <= n;
      repeat (3) @(posedge pclk);
      #1;
   endtask

   initial begin
      {psel, penable, pwrite, gie, vack, pin, err} = 7'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'hF;
      pos_mv = 12'h100;
      neg_mv = 12'h200;
      {mismatches, comparisons, cyc} = 0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      chk(prdata, 32'h0);
      chk1(pready, 1'b1);
      chk1(pslverr, 1'b0);
      chk1(pwr_off, 1'b0);
      chk1(req, 1'b0);
      chk1(irq, 1'b0);
      chk1(cap_src, capture_pin);
      presetn <= 1'b1;
      rdc(ACC_CSR_OFF, 32'h0);
      rdc(ACC_IRQ_MK_OFF, 32'h0);
      setv(12'h300, 12'h200);
      rdc(ACC_CSR_OFF, 32'h30);
      wr(ACC_CSR_OFF, 32'hD4);
      rdc(ACC_CSR_OFF, 32'h84);
      chk1(pwr_off, 1'b1);
      setv(12'h100, 12'h200);
      rdc(ACC_CSR_OFF, 32'h84);
      wr(ACC_CSR_OFF, 32'h0);
      chk1(pwr_off, 1'b0);
      wr(ACC_CSR_OFF, 32'h10);
      rdc(ACC_CSR_OFF, 32'h0);
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         up_hit = (s == ACC_SEL_TOGGLE) || (s == ACC_SEL_RISE);
         dn_hit = (s == ACC_SEL_TOGGLE) || (s == ACC_SEL_FALL);
         wr(ACC_CSR_OFF, {24'h0, 4'h1, 2'h0, s});
         setv(12'h300, 12'h200);
         rdc(ACC_CSR_OFF, {24'h0, 3'h1, up_hit, 2'h0, s});
         wr(ACC_CSR_OFF, {30'h0, s});
         rdc(ACC_CSR_OFF, {24'h0, 3'h1, up_hit, 2'h0, s});
         wr(ACC_CSR_OFF, {24'h0, 4'h1, 2'h0, s});
         setv(12'h100, 12'h200);
         rdc(ACC_CSR_OFF, {24'h0, 3'h0, dn_hit, 2'h0, s});
      end
      wr(ACC_CSR_OFF, 32'h10);
      wr(ACC_CSR_OFF, 32'h08);
      setv(12'h300, 12'h200);
      chk1(req, 1'b0);
      @(posedge pclk);
      gie <= 1'b1;
      #1 chk1(req, 1'b1);
      wr(ACC_CSR_OFF, 32'h0);
      chk1(req, 1'b0);
      wr(ACC_CSR_OFF, 32'h08);
      chk1(req, 1'b1);
      @(posedge pclk);
      vack <= 1'b1;
      @(posedge pclk);
      vack <= 1'b0;
      #1 chk1(req, 1'b0);
      rdc(ACC_CSR_OFF, 32'h28);
      wr(ACC_CSR_OFF, 32'h0);
      wr(ACC_IRQ_ST_OFF, 32'h3);
      rdc(ACC_IRQ_ST_OFF, 32'h0);
      wr(ACC_IRQ_MK_OFF, 32'h1);
      setv(12'h100, 12'h200);
      chk1(irq, 1'b1);
      rdc(ACC_IRQ_ST_OFF, 32'h1);
      wr(ACC_IRQ_MK_OFF, 32'h0);
      chk1(irq, 1'b0);
      wr(ACC_IRQ_MK_OFF, 32'h3);
      setv(12'h300, 12'h200);
      wr(ACC_IRQ_ST_OFF, 32'h1);
      rdc(ACC_IRQ_ST_OFF, 32'h2);
      chk1(irq, 1'b1);
      wr(ACC_IRQ_ST_OFF, 32'h2);
      chk1(irq, 1'b0);
      rdc(ACC_IRQ_MK_OFF, 32'h3);
      @(posedge pclk);
      pin <= 1'b1;
      #1 chk1(cap_src, 1'b1);
      @(posedge pclk);
      pin <= 1'b0;
      #1 chk1(cap_src, 1'b0);
      wr(ACC_CSR_OFF, 32'h04);
      chk1(cap_src, 1'b1);
      @(posedge pclk);
      pin <= 1'b1;
      setv(12'h100, 12'h200);
      chk1(cap_src, 1'b0);
      apb(1'b0, ACC_CSR_OFF, 32'h0);
      chk(rd, 32'h14);
      wr(ACC_CSR_OFF, rd | 32'h08);
      rdc(ACC_CSR_OFF, 32'h0C);
      chk1(req, 1'b0);
      @(posedge pclk);
      pstrb <= 4'hE;
      wr(ACC_CSR_OFF, 32'h80);
      @(posedge pclk);
      pstrb <= 4'hF;
      rdc(ACC_CSR_OFF, 32'h0C);
      chk1(pwr_off, 1'b0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0);
      chk1(err, 1'b1);
      end_sim();
   end
endmodule // analog_comparator_ctrl_tb
`default_nettype wire
